// File: verilog/ioc_pkg.sv
// constants, command codes and field layout of the input overcurrent status block
package ioc_pkg;
  // command codes on the management bus
  localparam logic [7:0]  CMD_CLEAR     = 8'h03;
  localparam logic [7:0]  CMD_FLT_LIM   = 8'h5B;
  localparam logic [7:0]  CMD_FLT_RSP   = 8'h5C;
  localparam logic [7:0]  CMD_WRN_LIM   = 8'h5D;
  localparam logic [7:0]  CMD_STAT_BYTE = 8'h78;
  localparam logic [7:0]  CMD_STAT_WORD = 8'h79;
  localparam logic [7:0]  CMD_STAT_IN   = 8'h7C;
  // reset and fixed values
  localparam logic [15:0] RST_FLT_LIM   = 16'h00FF;
  localparam logic [15:0] RST_WRN_LIM   = 16'h0019;
  localparam logic [7:0]  FLT_RSP_VAL   = 8'hC0;
  // linear format field positions
  localparam int          EXP_HI        = 15;
  localparam int          EXP_LO        = 11;
  localparam int          MAN_HI        = 10;
  localparam int          MAN_LO        = 0;
  // status bit positions
  localparam int          SB_OTHER      = 0;
  localparam int          SB_OFF        = 6;
  localparam int          SW_INPUT      = 13;
  localparam int          SI_OC_FAULT   = 2;
  localparam int          SI_OC_WARN    = 1;
  // bus framing
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [1:0]  IDX_CMD       = 2'h0;
  localparam logic [1:0]  IDX_LO        = 2'h1;
  localparam logic [1:0]  IDX_HI        = 2'h2;
  // bus slave states
  typedef enum logic [2:0] {
    IOC_IDLE, IOC_ADDR, IOC_AACK, IOC_WR, IOC_WACK, IOC_RD, IOC_RACK
  } ioc_state_t;
endpackage

// File: verilog/ioc_linear_cmp.sv
// compares a fixed-point current against a limit held in linear format
`timescale 1ns/1ps
module ioc_linear_cmp #(
  parameter int IW   = 16,
  parameter int FRAC = 4
) (
  // limit word and measured current
  input  wire logic [15:0]   limit,
  input  wire logic [IW-1:0] iin,
  // result
  output logic               reached
);
  logic signed [4:0]  lim_exp;
  logic signed [10:0] lim_man;
  int                 sh;
  logic [63:0]        lhs;
  logic [63:0]        rhs;

  // scale current and limit onto a common grid and compare
  always_comb begin
    lim_exp = $signed(limit[ioc_pkg::EXP_HI:ioc_pkg::EXP_LO]);
    lim_man = $signed(limit[ioc_pkg::MAN_HI:ioc_pkg::MAN_LO]);
    sh      = int'(lim_exp) + FRAC;
    lhs     = 64'(iin);
    rhs     = 64'(unsigned'(lim_man[9:0]));
    if (sh >= 0) begin
      rhs = rhs << sh; // mantissa times two to the power of exponent plus FRAC
    end else begin
      lhs = lhs << (-sh);
    end
    reached = lim_man[10] | (lhs >= rhs); // a negative limit is always reached
  end
endmodule

// File: verilog/ioc_fault_status.sv
// input overcurrent limits, fault latch and status summary behind a two-wire command bus
`timescale 1ns/1ps
module ioc_fault_status #(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int         IW       = 16,
  parameter int         FRAC     = 4
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // two-wire bus pins, open drain
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_n,
  // measured input current, unsigned amperes with FRAC fraction bits
  input  wire logic [IW-1:0] iin_amps,
  // outputs to host and power stage
  output logic               host_alert_out,
  output logic               regulator_fault_out,
  output logic               conv_enable_out
);
  ioc_pkg::ioc_state_t st_r;
  logic [2:0]          scl_q;
  logic [2:0]          sda_q;
  logic                scl_rise;
  logic                scl_fall;
  logic                bus_start;
  logic                bus_stop;
  logic [7:0]          shreg_r;
  logic [2:0]          bitcnt_r;
  logic [1:0]          bidx_r;
  logic [7:0]          cmd_r;
  logic [7:0]          wr_lo_r;
  logic                rw_r;
  logic                sda_low_r;
  logic                clr;
  logic [15:0]         fault_lim_r;
  logic [15:0]         warn_lim_r;
  logic                flt;
  logic                wrn;
  logic                other_r;
  logic                input_r;
  logic                sin_flt_r;
  logic                sin_wrn_r;
  logic                off_r;
  logic [7:0]          stat_byte;
  logic [15:0]         stat_word;
  logic [7:0]          stat_in;
  logic [7:0]          rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // bus edge and condition detection on synchronised levels
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign bus_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign rx_byte   = {shreg_r[6:0], sda_q[1]};

  ////////////////////////////////////////////////////////////////////////////
  // read data for a command and byte index; low byte first for words
  function automatic logic [7:0] rd_byte(input logic [7:0] c, input logic [1:0] i,
                                         input logic [15:0] fl, input logic [15:0] wl,
                                         input logic [15:0] sw, input logic [7:0] si);
    logic [15:0] w;
    w = 16'h0000;
    unique case (c)
      ioc_pkg::CMD_FLT_LIM:   w = fl;
      ioc_pkg::CMD_FLT_RSP:   w = {8'h00, ioc_pkg::FLT_RSP_VAL}; // fixed, read only
      ioc_pkg::CMD_WRN_LIM:   w = wl;
      ioc_pkg::CMD_STAT_BYTE: w = {8'h00, sw[7:0]}; // same storage as word low
      ioc_pkg::CMD_STAT_WORD: w = sw;
      ioc_pkg::CMD_STAT_IN:   w = {8'h00, si};
      default:                w = 16'h0000;
    endcase
    return (i == ioc_pkg::IDX_CMD) ? w[7:0] : w[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state machine, shifting on clock rise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r     <= ioc_pkg::IOC_IDLE;
      shreg_r  <= 8'h00;
      bitcnt_r <= 3'h0;
      bidx_r   <= 2'h0;
      cmd_r    <= 8'h00;
      rw_r     <= 1'b0;
    end else if (bus_start) begin
      st_r     <= ioc_pkg::IOC_ADDR;
      bitcnt_r <= 3'h0;
      bidx_r   <= 2'h0;
    end else if (bus_stop) begin
      st_r <= ioc_pkg::IOC_IDLE;
    end else if (scl_rise) begin
      unique case (st_r)
        ioc_pkg::IOC_IDLE: st_r <= ioc_pkg::IOC_IDLE;
        ioc_pkg::IOC_ADDR, ioc_pkg::IOC_WR: begin
          shreg_r  <= rx_byte;
          bitcnt_r <= bitcnt_r + 3'h1;
          if (bitcnt_r == ioc_pkg::LAST_BIT) begin
            if (st_r == ioc_pkg::IOC_WR) begin
              st_r <= ioc_pkg::IOC_WACK;
            end else if (rx_byte[7:1] == DEV_ADDR) begin
              st_r <= ioc_pkg::IOC_AACK;
              rw_r <= rx_byte[0];
            end else begin
              st_r <= ioc_pkg::IOC_IDLE;
            end
          end
        end
        ioc_pkg::IOC_AACK: begin
          bitcnt_r <= 3'h0;
          if (rw_r) begin
            st_r    <= ioc_pkg::IOC_RD;
            bidx_r  <= 2'h0;
            shreg_r <= rd_byte(cmd_r, 2'h0, fault_lim_r, warn_lim_r, stat_word, stat_in);
          end else begin
            st_r <= ioc_pkg::IOC_WR;
          end
        end
        ioc_pkg::IOC_WACK: begin
          st_r     <= ioc_pkg::IOC_WR;
          bitcnt_r <= 3'h0;
          if (bidx_r == ioc_pkg::IDX_CMD) begin
            cmd_r <= shreg_r;
          end
          if (bidx_r != ioc_pkg::IDX_HI) begin
            bidx_r <= bidx_r + 2'h1;
          end
        end
        ioc_pkg::IOC_RD: begin
          shreg_r  <= {shreg_r[6:0], 1'b0};
          bitcnt_r <= bitcnt_r + 3'h1;
          if (bitcnt_r == ioc_pkg::LAST_BIT) begin
            st_r <= ioc_pkg::IOC_RACK;
          end
        end
        ioc_pkg::IOC_RACK: begin
          bitcnt_r <= 3'h0;
          bidx_r   <= bidx_r + 2'h1;
          st_r     <= sda_q[1] ? ioc_pkg::IOC_IDLE : ioc_pkg::IOC_RD; // nack ends read
          shreg_r  <= rd_byte(cmd_r, bidx_r + 2'h1, fault_lim_r, warn_lim_r, stat_word,
                              stat_in);
        end
      endcase
    end
  end

  // data and acknowledge drive, changed while the clock is low, released at stop
  always_ff @(posedge ref_clk) begin
    if (rst || bus_stop) begin
      sda_low_r <= 1'b0;
    end else if (scl_fall) begin
      unique case (st_r)
        ioc_pkg::IOC_AACK, ioc_pkg::IOC_WACK: sda_low_r <= 1'b1;
        ioc_pkg::IOC_RD:                      sda_low_r <= ~shreg_r[7];
        default:                              sda_low_r <= 1'b0;
      endcase
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low_r;

  // clear-faults command is taken when its command byte is acknowledged
  assign clr = scl_rise && !bus_start && !bus_stop && st_r == ioc_pkg::IOC_WACK
               && bidx_r == ioc_pkg::IDX_CMD && shreg_r == ioc_pkg::CMD_CLEAR;

  ////////////////////////////////////////////////////////////////////////////
  // limit registers; a word write lands when its high byte is acknowledged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_lim_r <= ioc_pkg::RST_FLT_LIM;
      warn_lim_r  <= ioc_pkg::RST_WRN_LIM;
      wr_lo_r     <= 8'h00;
    end else if (scl_rise && !bus_start && !bus_stop && st_r == ioc_pkg::IOC_WACK) begin
      if (bidx_r == ioc_pkg::IDX_LO) begin
        wr_lo_r <= shreg_r;
      end else if (bidx_r == ioc_pkg::IDX_HI && cmd_r == ioc_pkg::CMD_FLT_LIM) begin
        fault_lim_r <= {shreg_r, wr_lo_r};
      end else if (bidx_r == ioc_pkg::IDX_HI && cmd_r == ioc_pkg::CMD_WRN_LIM) begin
        warn_lim_r <= {shreg_r, wr_lo_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit comparators
  ioc_linear_cmp #(.IW(IW), .FRAC(FRAC)) u_fault_cmp (
    .limit   (fault_lim_r),
    .iin     (iin_amps),
    .reached (flt)
  );
  ioc_linear_cmp #(.IW(IW), .FRAC(FRAC)) u_warn_cmp (
    .limit   (warn_lim_r),
    .iin     (iin_amps),
    .reached (wrn)
  );

  // sticky status flags; a live condition wins over a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      other_r   <= 1'b0;
      input_r   <= 1'b0;
      sin_flt_r <= 1'b0;
      sin_wrn_r <= 1'b0;
    end else begin
      other_r   <= flt | wrn | (other_r & ~clr);
      input_r   <= flt | wrn | (input_r & ~clr);
      sin_flt_r <= flt | (sin_flt_r & ~clr);
      sin_wrn_r <= wrn | (sin_wrn_r & ~clr);
    end
  end

  // shutdown latch, no restart until cleared
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      off_r <= 1'b0;
    end else begin
      off_r <= flt | (off_r & ~clr);
    end
  end

  // status views and outputs
  always_comb begin
    stat_byte                   = 8'h00;
    stat_byte[ioc_pkg::SB_OFF]  = off_r;
    stat_byte[ioc_pkg::SB_OTHER] = other_r;
    stat_word                   = {8'h00, stat_byte};
    stat_word[ioc_pkg::SW_INPUT] = input_r;
    stat_in                     = 8'h00;
    stat_in[ioc_pkg::SI_OC_FAULT] = sin_flt_r;
    stat_in[ioc_pkg::SI_OC_WARN] = sin_wrn_r;
  end

  assign host_alert_out      = other_r | input_r;
  assign regulator_fault_out = sin_flt_r;
  assign conv_enable_out     = ~off_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fault_off;
    @(posedge ref_clk) disable iff (rst) flt |=> off_r && !conv_enable_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not latch off");

  property p_fault_flags;
    @(posedge ref_clk) disable iff (rst)
      flt |=> other_r && stat_word[ioc_pkg::SW_INPUT] && stat_in[ioc_pkg::SI_OC_FAULT]
              && host_alert_out && regulator_fault_out;
  endproperty
  a_fault_flags: assert property (p_fault_flags) else $error("fault flags missing");

  property p_warn_flags;
    @(posedge ref_clk) disable iff (rst)
      wrn |=> stat_byte[ioc_pkg::SB_OTHER] && input_r && stat_in[ioc_pkg::SI_OC_WARN]
              && host_alert_out;
  endproperty
  a_warn_flags: assert property (p_warn_flags) else $error("warning flags missing");

  property p_stay_off;
    @(posedge ref_clk) disable iff (rst) off_r && !clr |=> off_r && !conv_enable_out;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("output re-enabled early");

  property p_byte_word;
    @(posedge ref_clk) disable iff (rst)
      rd_byte(ioc_pkg::CMD_STAT_BYTE, 2'h0, fault_lim_r, warn_lim_r, stat_word, stat_in)
      == rd_byte(ioc_pkg::CMD_STAT_WORD, 2'h0, fault_lim_r, warn_lim_r, stat_word, stat_in);
  endproperty
  a_byte_word: assert property (p_byte_word) else $error("status byte differs");

  property p_input_latch;
    @(posedge ref_clk) disable iff (rst) $rose(input_r) |-> $past(flt) || $past(wrn);
  endproperty
  a_input_latch: assert property (p_input_latch) else $error("input bit without cause");

  property p_alert_release;
    @(posedge ref_clk) disable iff (rst)
      (clr && !flt && !wrn) ##1 (!flt && !wrn) |-> !host_alert_out;
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert not released");

  property p_fault_cmp;
    @(posedge ref_clk) disable iff (rst)
      fault_lim_r[ioc_pkg::EXP_HI:ioc_pkg::EXP_LO] == 5'h00 && !fault_lim_r[ioc_pkg::MAN_HI]
      |-> flt == ({16'h0000, iin_amps} >= ({22'h0, fault_lim_r[9:0]} << FRAC));
  endproperty
  a_fault_cmp: assert property (p_fault_cmp) else $error("fault compare wrong");

  property p_warn_reset;
    @(posedge ref_clk) $fell(rst) |-> warn_lim_r == ioc_pkg::RST_WRN_LIM;
  endproperty
  a_warn_reset: assert property (p_warn_reset) else $error("warning limit reset wrong");
endmodule

// File: sim/ioc_host_model.sv
// bus host model: paces the two-wire clock and data, open drain with a pull-up
`timescale 1ns/1ps
module ioc_host_model (
  // pacing clock and wire level seen on the data line
  input  wire logic ref_clk,
  input  wire logic sda_line,
  // driven pins: clock level, data pulled low when set
  output logic      scl,
  output logic      sda_low
);
  // idle bus: clock stands high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // waits n cycles so every pin change lands on a falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  // stop: data rises while the clock is high, then the clock stands still
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b0;
    tick(4);
  endtask
  // one bit: data set in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(3);
    s = sda_line;
    tick(1);
    scl = 1'b0;
    tick(2);
  endtask
  // byte out, msb first, then the device's acknowledge (low = taken)
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask
  // byte in, msb first, then our acknowledge or not-acknowledge
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule

// File: sim/input_overcurrent_fault_status_bench.sv
// bench: host model, current stimulus and a reference model of the status block
`timescale 1ns/1ps
module input_overcurrent_fault_status_bench;
  logic        ref_clk;
  logic        rst;
  logic        scl;
  logic        sda_low;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe_n;
  logic [15:0] iin_amps;
  logic        host_alert_out;
  logic        regulator_fault_out;
  logic        conv_enable_out;
  int          err_total;
  int          n_checks;
  int          flt_thr;
  int          wrn_thr;
  int          e;
  int          m;
  bit          warn_s;
  bit          flt_s;
  bit          off_s;
  logic [15:0] rv;
  logic [15:0] lf;
  logic [15:0] w;
  // wired-and data line with pull-up
  assign sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));
  ioc_fault_status #(.DEV_ADDR(7'h40), .IW(16), .FRAC(4)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .iin_amps(iin_amps), .host_alert_out(host_alert_out),
    .regulator_fault_out(regulator_fault_out), .conv_enable_out(conv_enable_out));
  ioc_host_model i_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////
  // threshold in 1/16 A from a linear word; negative mantissa always reached
  function automatic int thr(input logic [15:0] x);
    int ex;
    int mx;
    ex = $signed(x[15:11]);
    mx = $signed(x[10:0]);
    return (mx < 0) ? 0 : (mx <<< (ex + 4));
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read of one or two bytes through a repeated start
  task automatic rd(input logic [7:0] cmd, input int nb, output logic [15:0] v);
    logic a;
    v = 16'h0000;
    i_host.start();
    i_host.wbyte(8'h80, a);
    check({15'h0, a}, 16'h0000);
    i_host.wbyte(cmd, a);
    i_host.start();
    i_host.wbyte(8'h81, a);
    i_host.rbyte(nb == 1, v[7:0]);
    if (nb == 2) begin
      i_host.rbyte(1'b1, v[15:8]);
    end
    i_host.stop();
  endtask
  // write of a command alone or with a word, low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int nb);
    logic a;
    i_host.start();
    i_host.wbyte(8'h80, a);
    check({15'h0, a}, 16'h0000);
    i_host.wbyte(cmd, a);
    if (nb == 2) begin
      i_host.wbyte(v[7:0], a);
      i_host.wbyte(v[15:8], a);
    end
    i_host.stop();
    if (cmd == ioc_pkg::CMD_CLEAR) begin
      warn_s = (int'(iin_amps) >= wrn_thr);
      flt_s  = (int'(iin_amps) >= flt_thr);
      off_s  = flt_s;
    end
  endtask
  // new current at a falling edge, then the sticky flags of the model
  task automatic drive(input int v);
    @(negedge ref_clk);
    iin_amps = v[15:0];
    repeat (4) @(negedge ref_clk);
    if (v >= wrn_thr) warn_s = 1'b1;
    if (v >= flt_thr) begin
      flt_s = 1'b1;
      off_s = 1'b1;
    end
  endtask
  // summary byte, word, input status and the three outputs against the model
  task automatic stat_chk();
    logic [7:0] sb;
    sb = {1'b0, off_s, 5'h00, warn_s | flt_s};
    rd(ioc_pkg::CMD_STAT_BYTE, 1, rv);
    check(rv, {8'h00, sb});
    rd(ioc_pkg::CMD_STAT_WORD, 2, rv);
    check(rv, {2'h0, warn_s | flt_s, 5'h00, sb});
    rd(ioc_pkg::CMD_STAT_IN, 1, rv);
    check(rv, {13'h0, flt_s, warn_s, 1'b0});
    check({13'h0, host_alert_out, regulator_fault_out, conv_enable_out},
          {13'h0, warn_s | flt_s, flt_s, ~off_s});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  // main sequence
  initial begin
    logic a;
    rst = 1'b1;
    iin_amps = 16'h0000;
    err_total = 0;
    n_checks = 0;
    lf = 16'h0008;
    wrn_thr = thr(16'h0019);
    flt_thr = thr(16'h00FF);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // reset values, read-only response, foreign address refused
    rd(ioc_pkg::CMD_FLT_LIM, 2, rv);
    check(rv, 16'h00FF);
    rd(ioc_pkg::CMD_WRN_LIM, 2, rv);
    check(rv, 16'h0019);
    wr(ioc_pkg::CMD_FLT_RSP, 16'h0000, 2);
    rd(ioc_pkg::CMD_FLT_RSP, 1, rv);
    check(rv, 16'h00C0);
    i_host.start();
    i_host.wbyte(8'h84, a);
    i_host.stop();
    check({15'h0, a}, 16'h0001);
    stat_chk();
    $display("test reset done");
    // warning at its boundary, default then random limits, clear with and without cause
    wr(ioc_pkg::CMD_FLT_LIM, 16'h13E8, 2);
    rd(ioc_pkg::CMD_FLT_LIM, 2, rv);
    check(rv, 16'h13E8);
    flt_thr = thr(16'h13E8);
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      e = int'(lf[15:8] % 8'h05) - 2;
      m = 1 + int'(lf[7:0]);
      w = (k == 0) ? 16'h0019 : {e[4:0], m[10:0]};
      wr(ioc_pkg::CMD_WRN_LIM, w, 2);
      wrn_thr = thr(w);
      drive(wrn_thr - 1);
      stat_chk();
      drive(wrn_thr);
      stat_chk();
      wr(ioc_pkg::CMD_CLEAR, 16'h0000, 0);
      stat_chk();
      drive(0);
      wr(ioc_pkg::CMD_CLEAR, 16'h0000, 0);
      stat_chk();
    end
    $display("test warning done");
    // fault at its boundary, latch-off held after the cause goes, then cleared
    wr(ioc_pkg::CMD_FLT_LIM, 16'h00FF, 2);
    flt_thr = thr(16'h00FF);
    drive(flt_thr - 1);
    stat_chk();
    drive(flt_thr);
    stat_chk();
    drive(0);
    stat_chk();
    wr(ioc_pkg::CMD_CLEAR, 16'h0000, 0);
    stat_chk();
    $display("test fault done");
    conclude();
  end
endmodule
